// File: rtl/margin_fault_pkg.sv
// Purpose: shared constants for the margin, current-offset and fault-response register bank
// Assumes: command-code addressed register port, 100 MHz clock
// Notes: offsets are the command codes themselves
package margin_fault_pkg;
  // command codes
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_CUR_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_ACTION = 8'h41;
  localparam logic [7:0] CMD_UV_ACTION = 8'h45;
  // reset and fixed values
  localparam logic [7:0] MARGIN_RESET = 8'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] OV_ACTION_VAL = 8'h80;
  localparam logic [7:0] UV_ACTION_VAL = 8'hBA;
  // linear field positions
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;
  localparam int MANT_LSB = 0;
  // status bit positions
  localparam int SB_VOUT_OV = 5;
  localparam int SB_OTHER = 0;
  localparam int SW_VOUT = 15;
  localparam int SV_OV = 7;
  localparam int SV_UV = 4;
  // operation modes
  localparam logic [1:0] OP_NOMINAL = 2'h0;
  localparam logic [1:0] OP_MARGIN_LOW = 2'h1;
  // restart delay
  localparam int RETRY_MS = 22;
  localparam int CLK_MHZ = 100;
  localparam int RETRY_CYCLES = RETRY_MS * 1000 * CLK_MHZ;
endpackage : margin_fault_pkg

// File: rtl/margin_fault_regs.sv
// Purpose: margin-low target, current offset trim and fixed fault responses
// Assumes: host accesses arrive as one-cycle strobes with command code and word data
module margin_fault_regs
  import margin_fault_pkg::*;
#(
  parameter int RETRY_CNT = RETRY_CYCLES
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // host register port
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // operating mode and vid selection
  input wire logic [1:0] op_mode,
  input wire logic [7:0] nominal_vid,
  input wire logic vid_protocol_select,
  input wire logic vendor_vid_protocol_reg,
  input wire logic vendor_override,
  // telemetry
  input wire logic signed [15:0] raw_iout,
  output logic signed [15:0] read_iout,
  // fault events and clear
  input wire logic ov_fault,
  input wire logic uv_fault,
  input wire logic clear_faults,
  // status and converter control
  output logic [7:0] status_byte,
  output logic [15:0] status_word,
  output logic [7:0] status_vout,
  output logic host_alert,
  output logic conv_enable,
  output logic [8:0] target_code
);
  // register state
  logic [7:0] margin_q, margin_d;
  logic [15:0] trim_q, trim_d;
  logic ov_q, ov_d; // overvoltage latched off
  logic uv_q, uv_d; // undervoltage status
  logic waiting_q, waiting_d; // restart delay running
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] rdat_q, rdat_d;
  logic rv_q, rv_d;
  logic signed [15:0] iout_q, iout_d;
  logic en_q, en_d;
  logic [8:0] tgt_q, tgt_d;
  logic prot_sel;
  logic signed [15:0] trim_amps;

  // protocol selection: register overrides the pin when enabled
  assign prot_sel = vendor_override ? vendor_vid_protocol_reg : vid_protocol_select;

  // scale trim to amps; shift by exponent (integer amps, fractions dropped)
  always_comb
  begin
    logic signed [4:0] ex;
    logic signed [15:0] man;
    ex = trim_q[EXP_MSB:EXP_LSB];
    man = {{5{trim_q[MANT_MSB]}}, trim_q[MANT_MSB:MANT_LSB]};
    if (ex < 0)
      trim_amps = man >>> (-ex);
    else
      trim_amps = man <<< ex;
  end

  // next-state for registers, faults, retry timer, read path
  always_comb
  begin
    margin_d = margin_q;
    trim_d = trim_q;
    ov_d = ov_q;
    uv_d = uv_q;
    waiting_d = waiting_q;
    cnt_d = cnt_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    // writes; response registers are read-only and ignore writes
    if (wr_stb)
    begin
      unique case (cmd_code)
        CMD_MARGIN_LOW: margin_d = wr_data[7:0];
        CMD_CUR_OFFSET: trim_d = wr_data;
        default: ;
      endcase
    end
    // reads; byte reads use the low byte of the word
    if (rd_stb)
    begin
      rv_d = 1'b1;
      unique case (cmd_code)
        CMD_MARGIN_LOW: rdat_d = {8'h00, margin_q};
        CMD_CUR_OFFSET: rdat_d = trim_q;
        CMD_OV_ACTION: rdat_d = {8'h00, OV_ACTION_VAL};
        CMD_UV_ACTION: rdat_d = {8'h00, UV_ACTION_VAL};
        default: rdat_d = 16'h0000;
      endcase
    end
    // fault clear first so that a simultaneous event wins
    if (clear_faults)
    begin
      ov_d = 1'b0;
      uv_d = 1'b0;
    end
    if (ov_fault)
      ov_d = 1'b1;
    // restart timer counts down after undervoltage shutdown
    if (waiting_q)
    begin
      if (cnt_q == 32'h0000_0000)
        waiting_d = 1'b0;
      else
        cnt_d = cnt_q - 32'h0000_0001;
    end
    if (uv_fault)
    begin
      uv_d = 1'b1;
      waiting_d = 1'b1;
      cnt_d = 32'(RETRY_CNT - 1);
    end
  end

  // converter control, target selection and telemetry
  always_comb
  begin
    // overvoltage holds off until cleared; undervoltage only during retry delay
    en_d = !ov_d && !waiting_d;
    // telemetry word stays 16 bits; a sum past full scale wraps
    iout_d = 16'(raw_iout + trim_amps);
    if (op_mode == OP_MARGIN_LOW)
      tgt_d = {prot_sel, margin_q};
    else
      tgt_d = {prot_sel, nominal_vid};
  end

  // register stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      margin_q <= MARGIN_RESET;
      trim_q <= OFFSET_RESET;
      ov_q <= 1'b0;
      uv_q <= 1'b0;
      waiting_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
      rdat_q <= 16'h0000;
      rv_q <= 1'b0;
      iout_q <= 16'sh0000;
      en_q <= 1'b0;
      tgt_q <= 9'h000;
    end
    else if (ce)
    begin
      margin_q <= margin_d;
      trim_q <= trim_d;
      ov_q <= ov_d;
      uv_q <= uv_d;
      waiting_q <= waiting_d;
      cnt_q <= cnt_d;
      rdat_q <= rdat_d;
      rv_q <= rv_d;
      iout_q <= iout_d;
      en_q <= en_d;
      tgt_q <= tgt_d;
    end
  end

  // outputs straight from flops; status bits registered from the next state of the two fault flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_byte <= 8'h00;
      status_word <= 16'h0000;
      status_vout <= 8'h00;
      host_alert <= 1'b0;
    end
    else if (ce)
    begin
      status_byte <= 8'h00;
      status_byte[SB_VOUT_OV] <= ov_d;
      status_byte[SB_OTHER] <= uv_d;
      status_word <= 16'h0000;
      status_word[SW_VOUT] <= ov_d | uv_d;
      status_vout <= 8'h00;
      status_vout[SV_OV] <= ov_d;
      status_vout[SV_UV] <= uv_d;
      host_alert <= ov_d | uv_d;
    end
  end

  assign rd_data = rdat_q;
  assign rd_valid = rv_q;
  assign read_iout = iout_q;
  assign conv_enable = en_q;
  assign target_code = tgt_q;

  // checks
  chk_ov_latch: assert property (@(posedge clk) disable iff (rst)
    ce && ov_fault ##1 ce |-> !conv_enable && host_alert && status_byte[SB_VOUT_OV])
    else $error("overvoltage did not latch off");
  chk_ov_hold: assert property (@(posedge clk) disable iff (rst)
    ov_q && !clear_faults && ce |=> ov_q && !conv_enable)
    else $error("overvoltage released without clear");
  chk_uv_alert: assert property (@(posedge clk) disable iff (rst)
    ce && uv_fault |=> host_alert && status_vout[SV_UV] && status_byte[SB_OTHER])
    else $error("undervoltage status missing");
  chk_uv_off: assert property (@(posedge clk) disable iff (rst)
    ce && uv_fault |=> !conv_enable)
    else $error("undervoltage did not shut down");
  chk_margin_hi_zero: assert property (@(posedge clk) disable iff (rst)
    ce && rd_stb && cmd_code == CMD_MARGIN_LOW |=> rd_data[15:8] == 8'h00 && rd_valid)
    else $error("margin upper byte not zero");
  chk_ov_fixed: assert property (@(posedge clk) disable iff (rst)
    ce && rd_stb && cmd_code == CMD_OV_ACTION |=> rd_data == 16'h0080)
    else $error("overvoltage response wrong");
  chk_uv_fixed: assert property (@(posedge clk) disable iff (rst)
    ce && rd_stb && cmd_code == CMD_UV_ACTION |=> rd_data == 16'h00BA)
    else $error("undervoltage response wrong");
  chk_margin_write: assert property (@(posedge clk) disable iff (rst)
    ce && wr_stb && cmd_code == CMD_MARGIN_LOW |=> margin_q == $past(wr_data[7:0]))
    else $error("margin write lost");
  chk_trim_write: assert property (@(posedge clk) disable iff (rst)
    ce && wr_stb && cmd_code == CMD_CUR_OFFSET |=> trim_q == $past(wr_data))
    else $error("trim write lost");
  chk_margin_sel: assert property (@(posedge clk) disable iff (rst)
    ce && op_mode == OP_MARGIN_LOW |=> target_code[7:0] == $past(margin_q))
    else $error("margin target not applied");
  cov_ov: cover property (@(posedge clk) disable iff (rst) ce && ov_fault);
  cov_uv_retry: cover property (@(posedge clk) disable iff (rst)
    waiting_q ##1 !waiting_q);
  cov_margin: cover property (@(posedge clk) disable iff (rst)
    ce && op_mode == OP_MARGIN_LOW);
endmodule : margin_fault_regs

// File: sim/host_model.sv
// Purpose: host side model issuing command-code register accesses
// Assumes: strobes are taken on the rising clk edge, one access at a time
// Notes: released command and data lines show the inverse of their last value; both strobes return low
module host_model
(
  // clock
  input wire logic clk,
  // register port toward the device
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] cmd_code,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial
  begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_code = 8'h00;
    wr_data = 16'h0000;
  end
  // one whole word per access, held for exactly one taken edge
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    wr_stb <= w;
    rd_stb <= ~w;
    cmd_code <= c;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    // stale values would hide a late sample in the device
    cmd_code <= ~c;
    wr_data <= ~d;
  endtask : access
endmodule : host_model

// File: sim/tb.sv
// Purpose: self-checking bench for the margin and fault register bank
// Assumes: retry delay shortened to RC cycles
// Notes: read answers are matched in order against a queue
`define CHK(n, e, a) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("Error %s expected %h seen %h", n, e, a); \
    end \
  end
module tb
  import margin_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // dropped once to show that state freezes
  logic [4:0] st; // snapshot of run, alert and three status bits
  logic [1:0] op_mode = OP_NOMINAL;
  logic [7:0] nvid = 8'h00;
  logic [2:0] pins = 3'b000; // override, register, pin
  logic [15:0] raw = 16'h0000;
  logic [2:0] evt = 3'b000; // ov, uv, clear
  logic wr_stb, rd_stb, rd_valid, host_alert, conv_enable;
  logic [7:0] cmd_code, status_byte, status_vout, r, m;
  logic [15:0] wr_data, rd_data, status_word, read_iout, e;
  logic [8:0] target_code;
  logic [15:0] exp_q[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  host_model host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_code(cmd_code),
    .wr_data(wr_data));
  margin_fault_regs #(.RETRY_CNT(RC)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_code(cmd_code), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .op_mode(op_mode), .nominal_vid(nvid),
    .vid_protocol_select(pins[0]), .vendor_vid_protocol_reg(pins[1]),
    .vendor_override(pins[2]), .raw_iout(raw), .read_iout(read_iout),
    .ov_fault(evt[2]), .uv_fault(evt[1]), .clear_faults(evt[0]),
    .status_byte(status_byte), .status_word(status_word), .status_vout(status_vout),
    .host_alert(host_alert), .conv_enable(conv_enable), .target_code(target_code));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // watcher: oldest note against each read answer, plus hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1)
    begin
      `CHK("rd_data", exp_q[0], rd_data)
      exp_q.delete(0);
    end
    if (cyc == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic rd(input logic [7:0] c, input logic [15:0] x);
    exp_q.push_back(x);
    host.access(1'b0, c, 16'h0000);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.access(1'b1, c, d);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle event pulse, sampled after the taking edge
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 3'b000;
    #1;
  endtask : pulse
  initial
  begin
    r = 8'h3F;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h26, 16'h0000);
    rd(8'h39, 16'h0000);
    rd(8'h41, 16'h0080);
    rd(8'h45, 16'h00BA);
    rd(8'h50, 16'h0000);
    // upper byte of the margin word must be dropped
    m = nxt(r);
    wr(8'h26, {8'hA5, m});
    rd(8'h26, {8'h00, m});
    // fixed responses ignore writes
    wr(8'h41, 16'h0000);
    wr(8'h45, 16'hFFFF);
    // a frozen block must not take a write
    ce <= 1'b0;
    wr(8'h26, 16'h0011);
    ce <= 1'b1;
    rd(8'h26, {8'h00, m});
    rd(8'h41, 16'h0080);
    rd(8'h45, 16'h00BA);
    // both fields keep negative values
    r = nxt(m);
    wr(8'h39, {5'h1F, 3'b111, r});
    rd(8'h39, {5'h1F, 3'b111, r});
    // zero exponent keeps the trim in whole amps
    wr(8'h39, {8'h00, r});
    nvid <= nxt(r);
    raw <= {8'h00, nxt(r)};
    e = {8'h00, nxt(r)} + {8'h00, r};
    tick(3);
    `CHK("read_iout", e, read_iout)
    // pin then register picks the protocol; the other source disagrees
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      op_mode <= OP_MARGIN_LOW;
      pins <= {i[0], i[0], ~i[0]};
      tick(3);
      `CHK("target_code", {1'b1, m}, target_code)
    end
    // undervoltage: off and alert at once, restart after the delay
    pulse(3'b010);
    st = {conv_enable, host_alert, status_byte[0], status_word[15], status_vout[4]};
    `CHK("uv", 5'b01111, st)
    // off for exactly the retry count, back on at the edge after
    tick(RC - 1);
    `CHK("uv_off", 1'b0, conv_enable)
    tick(1);
    `CHK("uv_on", 1'b1, conv_enable)
    `CHK("uv_hold", 1'b1, status_vout[4])
    pulse(3'b001);
    // overvoltage stays off well past the retry delay
    pulse(3'b100);
    st = {conv_enable, host_alert, status_byte[5], status_word[15], status_vout[7]};
    `CHK("ov", 5'b01111, st)
    tick(RC + 10);
    `CHK("ov_off", 1'b0, conv_enable)
    // a fault landing together with the clear must win over it
    pulse(3'b101);
    `CHK("ov_set_wins", 1'b0, conv_enable)
    // only the clear lets the converter run again
    pulse(3'b001);
    st = {conv_enable, host_alert, status_byte[5], status_word[15], status_vout[7]};
    `CHK("ov_clear", 5'b10000, st)
    tick(2);
    stop_test();
  end
endmodule : tb
